//--- bench/erb_chk.sv
// port-level assertions for the event recorder
module erb_chk
   import erb_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic rd_req_in,
   input wire logic rd_valid_out,
   input wire logic [ERB_CNT_W-1:0] count_out,
   input wire logic [ERB_PTR_W-1:0] oldest_out,
   input wire logic [ERB_PTR_W-1:0] wr_ptr_out,
   input wire logic overflow_out,
   input wire logic stall_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int div_reg;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // ms divider mirror: a new write shows while the mirror reads 1
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) div_reg <= 0;
      else div_reg <= (div_reg == ERB_TICK_CYC - 1) ? 0 : div_reg + 1;
   end
   AST_WR_STEP: assert property ($changed(wr_ptr_out) |->
      wr_ptr_out == ($past(wr_ptr_out) == ERB_PTR_LAST ? ERB_PTR_RST
      : $past(wr_ptr_out) + 9'h001)) else $error("write pointer step");
   AST_OVF: assert property (overflow_out |->
      count_out == ERB_CNT_FULL && $past(count_out) == ERB_CNT_FULL
      && $changed(oldest_out)) else $error("overwrite when not full");
   AST_WR_TIME: assert property (
      $changed(wr_ptr_out) |-> div_reg == 1) else $error("write off tick");
   AST_WR_GAP: assert property ($changed(wr_ptr_out) |=>
      $stable(wr_ptr_out) [*8]) else $error("two writes in one ms");
   AST_CNT_UP: assert property ($changed(wr_ptr_out) &&
      !rd_valid_out && $past(count_out) != ERB_CNT_FULL |->
      count_out == $past(count_out) + 9'h001) else $error("count step");
   AST_RD_ACK: assert property (rd_req_in &&
      count_out != ERB_CNT_RST |=> rd_valid_out) else $error("no answer");
   AST_RD_OLD: assert property (rd_valid_out |-> oldest_out ==
      ($past(oldest_out) == ERB_PTR_LAST ? ERB_PTR_RST
      : $past(oldest_out) + 9'h001)) else $error("oldest step");
   AST_NO_STALL: assert property (!stall_out)
      else $error("entry dropped");
endmodule

//--- bench/erb_src_model.sv
// event sources: levels move just after the rising edge
module erb_src_model (
   input wire logic clk_in,
   input wire logic [erb_pkg::ERB_NSRC-1:0] set_in,
   input wire logic [erb_pkg::ERB_NSRC-1:0] clr_in,
   output logic [erb_pkg::ERB_NSRC-1:0] src_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // one process only; set wins over clear so a pulse is never lost
   initial begin
      src_out = '0;
      forever @(posedge clk_in) src_out <= (src_out & ~clr_in) | set_in;
   end
endmodule

//--- bench/erb_top_bench.sv
// bench for the event recorder: merge, separate entries, readout
module erb_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import erb_pkg::*;
   logic clk_in = 0, nrst_in = 0, time_load_in = 0, rd_req_in = 0;
   logic [ERB_NSRC-1:0] set_v = '0, clr_v = '0, src, mask_in = '0;
   logic [ERB_TS_W-1:0] time_set_in = '0;
   logic [31:0] rng = 32'h0001_33c9;
   erb_snap_t snap_in = '0;
   erb_entry_t rd_data_out, e, exp_q[$];
   logic rd_valid_out, overflow_out, stall_out;
   logic [ERB_CNT_W-1:0] count_out;
   logic [ERB_PTR_W-1:0] oldest_out, wr_ptr_out;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   always #20 clk_in = ~clk_in;
   erb_src_model src_m (.clk_in, .set_in(set_v), .clr_in(clr_v),
      .src_out(src));
   erb_top dut (.clk_in, .nrst_in, .src_in(src), .mask_in, .snap_in,
      .time_set_in, .time_load_in, .rd_req_in, .rd_data_out, .rd_valid_out,
      .count_out, .oldest_out, .wr_ptr_out, .overflow_out, .stall_out);
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic cmp_entry(erb_entry_t x, erb_entry_t y);
      n_compared++;
      if (y !== x) begin
         error_cnt++;
         $display("BAD entry exp %h seen %h", x, y);
      end
   endtask
   task automatic cmp_num(string what, logic [8:0] x, logic [8:0] y);
      n_compared++;
      if (y !== x) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", what, x, y);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // bounded: one ms interval plus 1000 cycles, ample for the two-stage write
   task automatic wait_cnt(logic [8:0] v);
      for (int i = 0; i < 26000 && count_out !== v; i++) @(negedge clk_in);
   endtask
   // read answers against the oldest note; also the hang limit;
   // falling edge, so registered outputs are settled when looked at
   always @(negedge clk_in) begin
      cyc++;
      if (rd_valid_out === 1'b1 && exp_q.size() == 0)
         cmp_num("spare valid", 9'h000, 9'h001);
      else if (rd_valid_out === 1'b1)
         cmp_entry(exp_q.pop_front(), rd_data_out);
      if (cyc == 60000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      repeat (20) @(negedge clk_in);
      nrst_in = 1;
      @(negedge clk_in);
      rng = xs(rng);
      time_set_in = {16'h0000, rng};
      time_load_in = 1;
      snap_in = {6{xs(rng)}};
      mask_in[2] = 1'b1;
      @(negedge clk_in);
      time_load_in = 0;
      rd_req_in = 1;
      // two rises in one ms share an entry; masked rise adds nothing
      e = '{time_set_in, 32'h0000_0003, '0, snap_in};
      exp_q.push_back(e);
      set_v = 32'h0000_0005;
      @(negedge clk_in);
      rd_req_in = 0;
      set_v = 32'h0000_0002;
      @(negedge clk_in);
      set_v = '0;
      snap_in = ~snap_in;
      wait_cnt(9'h001);
      cmp_num("count", 9'h001, count_out);
      $display("merge test done");
      // a later fall gets its own entry, one ms on
      e = '{time_set_in + 48'h0000_0000_0001, '0, 32'h0000_0001, snap_in};
      exp_q.push_back(e);
      clr_v = 32'h0000_0005;
      @(negedge clk_in);
      clr_v = '0;
      @(negedge clk_in);
      snap_in = ~snap_in;
      wait_cnt(9'h002);
      cmp_num("count", 9'h002, count_out);
      cmp_num("write ptr", 9'h002, wr_ptr_out);
      $display("separate test done");
      // back-to-back reads drain oldest first
      rd_req_in = 1;
      repeat (2) @(negedge clk_in);
      rd_req_in = 0;
      repeat (2) @(negedge clk_in);
      cmp_num("count", 9'h000, count_out);
      cmp_num("oldest", 9'h002, oldest_out);
      cmp_num("overflow", 9'h000, 9'(overflow_out));
      cmp_num("pending", 9'h000, 9'(exp_q.size()));
      $display("readout test done");
      report_and_stop();
   end
endmodule
bind erb_top erb_chk chk (.clk_in, .nrst_in, .rd_req_in, .rd_valid_out,
   .count_out, .oldest_out, .wr_ptr_out, .overflow_out, .stall_out);

//--- src/erb_pkg.sv
// shared constants and carrier types for the event record ring buffer
package erb_pkg;
   localparam int ERB_DEPTH = 400;
   localparam int ERB_PTR_W = 9;
   localparam int ERB_CNT_W = 9;
   localparam int ERB_NSRC = 32;
   localparam int ERB_NVAL = 12;
   localparam int ERB_VAL_W = 16;
   localparam int ERB_TS_W = 48;
   localparam int ERB_CLK_HZ = 25_000_000;
   localparam int ERB_TICK_US = 1000;
   localparam int ERB_TICK_CYC = ERB_CLK_HZ / 1_000_000 * ERB_TICK_US;
   localparam int ERB_TICK_W = 15;
   localparam logic [ERB_PTR_W-1:0] ERB_PTR_RST = 9'h000;
   localparam logic [ERB_PTR_W-1:0] ERB_PTR_LAST = 9'h18f;
   localparam logic [ERB_CNT_W-1:0] ERB_CNT_RST = 9'h000;
   localparam logic [ERB_CNT_W-1:0] ERB_CNT_FULL = 9'h190;
   localparam logic [ERB_TS_W-1:0] ERB_TS_RST = 48'h0000_0000_0000;

   typedef logic [ERB_NVAL*ERB_VAL_W-1:0] erb_snap_t;

   // one stored entry: which sources rose, which fell, when, and the values
   typedef struct packed {
      logic [ERB_TS_W-1:0] stamp;
      logic [ERB_NSRC-1:0] act;
      logic [ERB_NSRC-1:0] deact;
      erb_snap_t snap;
   } erb_entry_t;
endpackage

//--- src/erb_skid.sv
// two-entry buffer between the merge stage and the ring memory
module erb_skid (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire erb_pkg::erb_entry_t data_in,
   input wire logic valid_in,
   output logic ready_out,
   output erb_pkg::erb_entry_t data_out,
   output logic valid_out,
   input wire logic ready_in
);
   import erb_pkg::*;
   erb_entry_t mem_reg [2];
   erb_entry_t mem_next [2];
   logic rd_reg, rd_next, wr_reg, wr_next;
   logic [1:0] cnt_reg, cnt_next;
   logic push, pop;

   assign ready_out = (cnt_reg != 2'h2);
   assign valid_out = (cnt_reg != 2'h0);
   assign data_out = mem_reg[rd_reg];
   assign push = valid_in && ready_out;
   assign pop = valid_out && ready_in;

   // next state of the two slots and pointers
   always_comb begin
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wr_reg] = data_in;
         wr_next = ~wr_reg;
      end
      if (pop) begin
         rd_next = ~rd_reg;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'h1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'h1;
      end
   end

   // registers; slot contents need no reset, count guards them
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else begin
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge clk_in) begin
      mem_reg <= mem_next;
   end
endmodule

//--- src/erb_top.sv
// event recorder: 1 ms merge, timestamp, snapshot, 400-entry ring memory
// Function
// RULE_01: memory holds at most four hundred entries
// RULE_02: when full, new entry overwrites the oldest
// RULE_03: entry holds timestamp and twelve value snapshot
// RULE_04: simultaneous operations merge into one entry
// RULE_05: non-simultaneous operations give separate entries
// RULE_06: simultaneous means same one millisecond interval
// RULE_07: masked sources create nothing, displace nothing
// RULE_08: entry records activation versus deactivation
// RULE_09: pointers and count allow oldest-first readout
module erb_top (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [erb_pkg::ERB_NSRC-1:0] src_in,
   input wire logic [erb_pkg::ERB_NSRC-1:0] mask_in,
   input wire erb_pkg::erb_snap_t snap_in,
   input wire logic [erb_pkg::ERB_TS_W-1:0] time_set_in,
   input wire logic time_load_in,
   input wire logic rd_req_in,
   output erb_pkg::erb_entry_t rd_data_out,
   output logic rd_valid_out,
   output logic [erb_pkg::ERB_CNT_W-1:0] count_out,
   output logic [erb_pkg::ERB_PTR_W-1:0] oldest_out,
   output logic [erb_pkg::ERB_PTR_W-1:0] wr_ptr_out,
   output logic overflow_out,
   output logic stall_out
);
   import erb_pkg::*;

   localparam logic [ERB_TICK_W-1:0] TICK_LAST =
      ERB_TICK_W'(ERB_TICK_CYC - 1);

   // ring storage, declared here as an array
   erb_entry_t ring_mem [ERB_DEPTH];

   logic [ERB_TICK_W-1:0] div_reg, div_next;
   logic tick;
   logic [ERB_TS_W-1:0] ts_reg, ts_next;
   logic [ERB_NSRC-1:0] prev_reg, prev_next;
   logic [ERB_NSRC-1:0] acc_act_reg, acc_act_next;
   logic [ERB_NSRC-1:0] acc_deact_reg, acc_deact_next;
   logic [ERB_TS_W-1:0] acc_ts_reg, acc_ts_next;
   erb_snap_t acc_snap_reg, acc_snap_next;
   logic acc_any_reg, acc_any_next;
   logic [ERB_NSRC-1:0] rise, fall;
   logic hit;
   erb_entry_t emit_data;
   logic emit_valid, buf_ready;
   erb_entry_t buf_data;
   logic buf_valid, buf_pop;
   logic [ERB_PTR_W-1:0] wr_reg, wr_next, old_reg, old_next;
   logic [ERB_CNT_W-1:0] cnt_reg, cnt_next;
   logic ovf_reg, ovf_next;
   erb_entry_t rdd_reg, rdd_next;
   logic rdv_reg, rdv_next;
   logic rd_take;

   // millisecond enable; also the time stamp resolution
   always_comb begin
      tick = (div_reg == TICK_LAST); // RULE_06
      div_next = tick ? '0 : div_reg + 1'b1;
      ts_next = ts_reg;
      if (time_load_in) begin
         ts_next = time_set_in;
      end else if (tick) begin
         ts_next = ts_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_reg <= '0;
         ts_reg <= ERB_TS_RST;
      end else begin
         div_reg <= div_next;
         ts_reg <= ts_next;
      end
   end

   // edge detection and merge of all operations within one interval;
   // the stamp and snapshot are caught at the first operation of it
   always_comb begin
      rise = src_in & ~prev_reg & ~mask_in; // RULE_07 RULE_08
      fall = ~src_in & prev_reg & ~mask_in; // RULE_07 RULE_08
      hit = |(rise | fall);
      prev_next = src_in;
      acc_act_next = acc_act_reg;
      acc_deact_next = acc_deact_reg;
      acc_ts_next = acc_ts_reg;
      acc_snap_next = acc_snap_reg;
      acc_any_next = acc_any_reg;
      emit_valid = 1'b0;
      emit_data = '{stamp: acc_ts_reg, act: acc_act_reg,
                    deact: acc_deact_reg, snap: acc_snap_reg}; // RULE_03
      if (tick && acc_any_reg) begin
         // interval closed: hand over, new operations start a fresh one
         emit_valid = 1'b1; // RULE_05
         acc_any_next = hit;
         acc_act_next = rise;
         acc_deact_next = fall;
         // tick-cycle edges belong to the next ms, so stamp with ts_next
         acc_ts_next = ts_next; // RULE_06
         acc_snap_next = snap_in; // RULE_03
      end else if (hit) begin
         if (!acc_any_reg) begin
            acc_ts_next = ts_next; // RULE_06
            acc_snap_next = snap_in; // RULE_03
         end
         acc_any_next = 1'b1;
         acc_act_next = acc_act_reg | rise; // RULE_04
         acc_deact_next = acc_deact_reg | fall; // RULE_04
      end
   end

   // a full buffer drops the closing entry; stall_out flags it
   assign stall_out = emit_valid && !buf_ready;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prev_reg <= '0;
         acc_act_reg <= '0;
         acc_deact_reg <= '0;
         acc_ts_reg <= ERB_TS_RST;
         acc_snap_reg <= '0;
         acc_any_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         acc_act_reg <= acc_act_next;
         acc_deact_reg <= acc_deact_next;
         acc_ts_reg <= acc_ts_next;
         acc_snap_reg <= acc_snap_next;
         acc_any_reg <= acc_any_next;
      end
   end

   erb_skid u_skid (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .data_in(emit_data),
      .valid_in(emit_valid),
      .ready_out(buf_ready),
      .data_out(buf_data),
      .valid_out(buf_valid),
      .ready_in(1'b1)
   );

   // ring drains one entry per cycle, so the buffer never holds two
   // for long; a read and a write in one cycle are both honoured
   assign buf_pop = buf_valid;
   assign rd_take = rd_req_in && (cnt_reg != ERB_CNT_RST);

   always_comb begin
      wr_next = wr_reg;
      old_next = old_reg;
      cnt_next = cnt_reg;
      ovf_next = 1'b0;
      rdv_next = rd_take;
      rdd_next = rdd_reg;
      if (rd_take) begin
         rdd_next = ring_mem[old_reg]; // RULE_09
      end
      if (buf_pop) begin
         wr_next = (wr_reg == ERB_PTR_LAST) ? ERB_PTR_RST
                                            : wr_reg + 1'b1; // RULE_01
      end
      if (rd_take || (buf_pop && cnt_reg == ERB_CNT_FULL)) begin
         old_next = (old_reg == ERB_PTR_LAST) ? ERB_PTR_RST
                                              : old_reg + 1'b1; // RULE_02
      end
      if (buf_pop && cnt_reg == ERB_CNT_FULL && !rd_take) begin
         ovf_next = 1'b1; // RULE_02
      end else if (buf_pop && !rd_take) begin
         cnt_next = cnt_reg + 1'b1; // RULE_09
      end else if (rd_take && !buf_pop) begin
         cnt_next = cnt_reg - 1'b1; // RULE_09
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_reg <= ERB_PTR_RST;
         old_reg <= ERB_PTR_RST;
         cnt_reg <= ERB_CNT_RST;
         ovf_reg <= 1'b0;
         rdv_reg <= 1'b0;
         rdd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         old_reg <= old_next;
         cnt_reg <= cnt_next;
         ovf_reg <= ovf_next;
         rdv_reg <= rdv_next;
         rdd_reg <= rdd_next;
      end
   end

   // memory write port, no reset on the array
   always_ff @(posedge clk_in) begin
      if (buf_pop) begin
         ring_mem[wr_reg] <= buf_data; // RULE_02
      end
   end

   assign rd_data_out = rdd_reg;
   assign rd_valid_out = rdv_reg;
   assign count_out = cnt_reg;
   assign oldest_out = old_reg;
   assign wr_ptr_out = wr_reg;
   assign overflow_out = ovf_reg;
endmodule
